/* bench/dcff_fifo_asserts.sv */
/*
  dcff_fifo_asserts: port checker for the fifo.
  assumes: bound from the bench; straps held after reset.
*/
`timescale 1ns/1ps
module dcff_fifo_asserts
  import dcff_pkg::*;
#(
  parameter int DEPTH = 65536,
  parameter int WIDTH = 9
)(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic write_clk,
  input wire logic read_clk,
  input wire logic mode_select_serial_in,
  input wire logic offset_load_n,
  input wire logic [WIDTH-1:0] data_out,
  input wire logic empty_flag_n,
  input wire logic full_flag_n,
  input wire logic output_ready_n,
  input wire logic input_ready_n,
  input wire logic almost_empty_n,
  input wire logic almost_full_n,
  input wire logic half_full_n,
  input wire logic serial_load_sel
);
  // ---------------------------------------------------------------
  // settle count: straps land a few edges after release
  // ---------------------------------------------------------------
  logic [2:0] settle_r;
  wire logic settled = settle_r == 3'h7;
  wire logic ft = mode_select_serial_in;
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      settle_r <= 3'h0;
    else if (!settled)
      settle_r <= settle_r + 3'h1;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_ft_std_idle: assert property (settled && ft |-> empty_flag_n && full_flag_n)
    else $error("std flags active in ft mode");
  a_std_ft_idle: assert property (settled && !ft |-> output_ready_n && input_ready_n)
    else $error("ft flags active in std mode");
  a_load_sel: assert property (settled |-> serial_load_sel == offset_load_n)
    else $error("load method not latched");
  a_empty_ae: assert property (settled && (ft ? output_ready_n : !empty_flag_n)
    |-> !almost_empty_n)
    else $error("almost empty high while empty");
  a_full_af: assert property (settled && (ft ? input_ready_n : !full_flag_n)
    |-> !almost_full_n && !half_full_n)
    else $error("full without almost full");
  // a change only follows a read clock edge, never idle time
  a_dout_read: assert property ($changed(data_out)
    |-> $past(read_clk, 2) || $past(read_clk, 3))
    else $error("data out moved without read edge");
  a_ef_stages: assert property (settled && !ft && $rose(empty_flag_n)
    |-> $past(write_clk, 4) && $past(write_clk, 5))
    else $error("empty flag rose too early");
  a_or_stages: assert property (settled && ft && $fell(output_ready_n)
    |-> $past(read_clk, 5) && $past(read_clk, 6))
    else $error("output ready fell too early");

  c_full: cover property (!ft && $fell(full_flag_n));
  c_ir: cover property (ft && $rose(input_ready_n));
  c_or: cover property (ft && $fell(output_ready_n));
endmodule // dcff_fifo_asserts

/* bench/dcff_fifo_test.sv */
/*
  dcff_fifo_test: both modes filled and drained, straps checked.
  assumes: link model and checker compiled before this file.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module dcff_fifo_test
  import dcff_pkg::*;
;
  // small depth keeps the run short; the parallel default offset still fits
  localparam int D = 256;
  localparam int N = 127;
  logic clk_sys, arst_n, mode_select_serial_in, offset_load_n;
  wire logic write_clk, write_enable_n, read_clk, read_enable_n;
  wire logic [8:0] data_in, data_out;
  wire logic empty_flag_n, full_flag_n, output_ready_n, input_ready_n;
  wire logic almost_empty_n, almost_full_n, half_full_n, serial_load_sel;
  int mismatches, compares, cap;
  logic [8:0] q[$];
  logic [8:0] x, y;

  initial
  begin
    clk_sys = 1'h0;
    forever #10 clk_sys = ~clk_sys;
  end

  dcff_link_model lm (.clk_sys, .write_clk, .write_enable_n, .data_in, .read_clk,
    .read_enable_n);
  dcff_fifo #(.DEPTH(D), .WIDTH(9)) dut (.clk_sys, .arst_n, .write_clk, .write_enable_n,
    .data_in, .read_clk, .read_enable_n, .mode_select_serial_in, .offset_load_n, .data_out,
    .empty_flag_n, .full_flag_n, .output_ready_n, .input_ready_n, .almost_empty_n,
    .almost_full_n, .half_full_n, .serial_load_sel);

  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic do_reset(input logic m, input logic l);
    @(posedge clk_sys);
    arst_n <= 1'h0;
    mode_select_serial_in <= m;
    offset_load_n <= l;
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'h1;
    repeat (8) @(posedge clk_sys);
  endtask

  task automatic check_flags(input logic ft, input int c);
    logic [6:0] e;
    e = {ft || c > 0, ft || c < D, !ft || c == 0, !ft || c >= D + 1, c >= N + 1 + ft,
      c < D - N + ft, c < D / 2 + 1 + ft};
    `CHK({empty_flag_n, full_flag_n, output_ready_n, input_ready_n, almost_empty_n,
      almost_full_n, half_full_n}, e)
  endtask

  initial
  begin
    repeat (100000) @(posedge clk_sys);
    mismatches++;
    close_out();
  end

  initial
  begin
    arst_n = 1'h0;
    mode_select_serial_in = 1'h0;
    offset_load_n = 1'h0;
    for (int m = 0; m < 2; m++)
    begin
      do_reset(m[0], 1'h0);
      `CHK(serial_load_sel, 1'h0)
      check_flags(m[0], 0);
      cap = D + m;
      for (int i = 0; q.size() < cap; i++)
      begin
        x = 9'(i) ^ 9'h0a5;
        if (i == 20)
        begin
          lm.xfer(x, 4'hf);
          y = q.pop_front();
          q.push_back(x);
          `CHK(data_out, m ? q[0] : y)
        end
        else
        begin
          lm.xfer(x, 4'hc);
          q.push_back(x);
        end
        if (m == 1 && i == 0)
        begin
          lm.xfer(x, 4'h2);
          lm.xfer(x, 4'h2);
          `CHK({output_ready_n, data_out}, {1'h1, 9'h000})
          lm.xfer(x, 4'h2);
          `CHK(data_out, x)
        end
        check_flags(m[0], q.size());
      end
      lm.xfer(9'h1ff, 4'hc);
      check_flags(m[0], cap);
      while (q.size() > 0)
      begin
        if (m == 1) `CHK(data_out, q[0])
        lm.xfer(9'h000, 4'h3);
        x = q.pop_front();
        if (m == 0) `CHK(data_out, x)
        check_flags(m[0], q.size());
      end
      lm.xfer(9'h000, 4'h3);
      check_flags(m[0], 0);
      if (m == 0) `CHK(data_out, x)
      $display("mode %0d test done", m);
    end
    do_reset(1'h0, 1'h1);
    `CHK({serial_load_sel, empty_flag_n}, 2'h2)
    $display("strap test done");
    close_out();
  end
endmodule // dcff_fifo_test

bind dcff_fifo dcff_fifo_asserts #(.DEPTH(DEPTH), .WIDTH(WIDTH)) u_chk (.clk_sys, .arst_n,
  .write_clk, .read_clk, .mode_select_serial_in, .offset_load_n, .data_out, .empty_flag_n,
  .full_flag_n, .output_ready_n, .input_ready_n, .almost_empty_n, .almost_full_n,
  .half_full_n, .serial_load_sel);

/* bench/dcff_link_model.sv */
/*
  dcff_link_model: writer and reader pins around the fifo.
  assumes: clk_sys well above the pin clocks; phases 4 clk each.
*/
`timescale 1ns/1ps
module dcff_link_model
  import dcff_pkg::*;
(
  input wire logic clk_sys,
  output logic write_clk,
  output logic write_enable_n,
  output logic [8:0] data_in,
  output logic read_clk,
  output logic read_enable_n
);
  initial
  begin
    write_clk = 1'h0;
    read_clk = 1'h0;
    write_enable_n = 1'h1;
    read_enable_n = 1'h1;
    data_in = 9'h000;
  end

  // sel: write clock, write enable, read clock, read enable
  task automatic xfer(input logic [8:0] d, input logic [3:0] sel);
  begin
    @(posedge clk_sys);
    data_in <= d;
    write_enable_n <= !sel[2];
    read_enable_n <= !sel[0];
    @(posedge clk_sys);
    write_clk <= sel[3];
    read_clk <= sel[1];
    repeat (4) @(posedge clk_sys);
    write_clk <= 1'h0;
    read_clk <= 1'h0;
    repeat (4) @(posedge clk_sys);
    write_enable_n <= 1'h1;
    read_enable_n <= 1'h1;
    // released bus shows no stale word
    data_in <= ~d;
  end
  endtask
endmodule // dcff_link_model

/* core/dcff_fifo.sv */
/*
  dcff_fifo: deep fifo with standard and fall-through timing, status flags.
  assumes: write and read clocks arrive as pins and are sampled on clk_sys,
  which must run well above twice either pin clock; depth a power of two.
*/
`timescale 1ns/1ps
`include "dcff_regs.svh"

module dcff_fifo
  import dcff_pkg::*;
#(
  parameter int DEPTH = 65536,
  parameter int WIDTH = 9
)(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic write_clk,
  input wire logic write_enable_n,
  input wire logic [WIDTH-1:0] data_in,
  input wire logic read_clk,
  input wire logic read_enable_n,
  input wire logic mode_select_serial_in,
  input wire logic offset_load_n,
  output logic [WIDTH-1:0] data_out,
  output logic empty_flag_n,
  output logic full_flag_n,
  output logic output_ready_n,
  output logic input_ready_n,
  output logic almost_empty_n,
  output logic almost_full_n,
  output logic half_full_n,
  output logic serial_load_sel
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [CW-1:0] HALF_C = CW'(DEPTH / 2);
  // offsets beyond the depth saturate, so a small build keeps sane thresholds
  localparam logic [CW-1:0] SER_OFF_C = (`DCFF_OFFSET_SERIAL_DEF > DEPTH) ? DEPTH_C :
    CW'(`DCFF_OFFSET_SERIAL_DEF);
  localparam logic [CW-1:0] PAR_OFF_C = (`DCFF_OFFSET_PARALLEL_DEF > DEPTH) ? DEPTH_C :
    CW'(`DCFF_OFFSET_PARALLEL_DEF);

  // -------------------------------------------------------------------
  // pin synchronisers; data rides the same two stages as its clock
  // -------------------------------------------------------------------
  localparam int SW = WIDTH + 6;
  logic [SW-1:0] pin_s1_r;
  logic [SW-1:0] pin_s2_r;
  logic wclk_d_r;
  logic rclk_d_r;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end
    else
    begin
      pin_s1_r <= {data_in, write_clk, write_enable_n, read_clk, read_enable_n,
                   mode_select_serial_in, offset_load_n};
      pin_s2_r <= pin_s1_r;
    end
  end

  logic [WIDTH-1:0] din_s;
  logic wclk_s;
  logic wen_n_s;
  logic rclk_s;
  logic ren_n_s;
  logic mode_s;
  logic load_s;
  assign {din_s, wclk_s, wen_n_s, rclk_s, ren_n_s, mode_s, load_s} = pin_s2_r;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wclk_d_r <= 1'b0;
      rclk_d_r <= 1'b0;
    end
    else
    begin
      wclk_d_r <= wclk_s;
      rclk_d_r <= rclk_s;
    end
  end

  logic wedge;
  logic redge;
  assign wedge = wclk_s & ~wclk_d_r;
  assign redge = rclk_s & ~rclk_d_r;

  // -------------------------------------------------------------------
  // master reset straps
  // -------------------------------------------------------------------
  // straps are caught once the synchroniser has filled after release
  logic [1:0] strap_cnt_r;
  logic ready_r;
  dcff_mode_t mode_r;
  dcff_load_t load_r;
  logic [CW-1:0] empty_off_r;
  logic [CW-1:0] full_off_r;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      strap_cnt_r <= '0;
      ready_r <= 1'b0;
      mode_r <= DCFF_MODE_STD;
      load_r <= DCFF_LOAD_PARALLEL;
      empty_off_r <= PAR_OFF_C;
      full_off_r <= PAR_OFF_C;
    end
    else if (!ready_r)
    begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      if (strap_cnt_r == `DCFF_STRAP_WAIT)
      begin
        ready_r <= 1'b1;
        mode_r <= mode_s ? DCFF_MODE_FT : DCFF_MODE_STD;
        if (load_s)
        begin
          load_r <= DCFF_LOAD_SERIAL;
          empty_off_r <= SER_OFF_C;
          full_off_r <= SER_OFF_C;
        end
        else
        begin
          load_r <= DCFF_LOAD_PARALLEL;
          empty_off_r <= PAR_OFF_C;
          full_off_r <= PAR_OFF_C;
        end
      end
    end
  end

  // -------------------------------------------------------------------
  // storage and pointers
  // -------------------------------------------------------------------
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [CW-1:0] mem_cnt_r;
  logic out_valid_r;
  logic [1:0] ft_cnt_r;
  logic is_ft;
  logic do_write;
  logic mem_pop;
  logic ft_load;
  logic std_read;
  logic ft_read;

  assign is_ft = (mode_r == DCFF_MODE_FT);
  assign do_write = ready_r & wedge & ~wen_n_s & (mem_cnt_r != DEPTH_C);
  assign std_read = ~is_ft & redge & ~ren_n_s & (mem_cnt_r != '0);
  assign ft_read = is_ft & redge & ~ren_n_s & out_valid_r;
  // first word falls through on the third read clock edge, no enable
  assign ft_load = is_ft & redge & ~out_valid_r & (mem_cnt_r != '0)
                   & (ft_cnt_r == `DCFF_FT_EDGES - 2'h1);
  assign mem_pop = std_read | ft_load | (ft_read & (mem_cnt_r != '0));

  always_ff @(posedge clk_sys)
  begin
    if (do_write)
      mem[wptr_r] <= din_s;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wptr_r <= '0;
    end
    else if (do_write)
    begin
      wptr_r <= wptr_r + AW'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rptr_r <= '0;
    end
    else if (mem_pop)
    begin
      rptr_r <= rptr_r + AW'(1);
    end
  end

  // simultaneous push and pop leaves the count alone
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mem_cnt_r <= '0;
    end
    else if (do_write && !mem_pop)
    begin
      mem_cnt_r <= mem_cnt_r + CW'(1);
    end
    else if (!do_write && mem_pop)
    begin
      mem_cnt_r <= mem_cnt_r - CW'(1);
    end
  end

  // -------------------------------------------------------------------
  // output register
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      data_out <= '0;
    end
    else if (mem_pop)
    begin
      data_out <= mem[rptr_r];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      out_valid_r <= 1'b0;
    end
    else if (ft_load)
    begin
      out_valid_r <= 1'b1;
    end
    else if (ft_read && mem_cnt_r == '0)
    begin
      out_valid_r <= 1'b0;
    end
  end

  // edges count only while a word waits behind an empty output register
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ft_cnt_r <= '0;
    end
    else if (!is_ft || out_valid_r || mem_cnt_r == '0)
    begin
      ft_cnt_r <= '0;
    end
    else if (redge)
    begin
      ft_cnt_r <= ft_cnt_r + 2'h1;
    end
  end

  // -------------------------------------------------------------------
  // flag thresholds on the word count held in one domain
  // -------------------------------------------------------------------
  logic [CW-1:0] total;
  dcff_flags_t raw;
  assign total = mem_cnt_r + CW'(is_ft & out_valid_r);

  always_comb
  begin
    raw.empty_n = (mem_cnt_r != '0);
    raw.full_n = ~is_ft ? (mem_cnt_r != DEPTH_C) : (total != DEPTH_C + CW'(1));
    if (!is_ft)
    begin
      raw.almost_empty_n = (total >= empty_off_r + CW'(1));
      raw.half_full_n = ~(total >= HALF_C + CW'(1));
      raw.almost_full_n = ~(total >= DEPTH_C - full_off_r);
    end
    else
    begin
      raw.almost_empty_n = (total >= empty_off_r + CW'(2));
      raw.half_full_n = ~(total >= HALF_C + CW'(2));
      raw.almost_full_n = ~(total >= DEPTH_C + CW'(1) - full_off_r);
    end
  end

  // -------------------------------------------------------------------
  // flag pipelines; depth differs per flag and mode
  // -------------------------------------------------------------------
  // staging adds latency but keeps the flag pins glitch free
  logic [`DCFF_STD_FLAG_STAGES-2:0] empty_pipe_r;
  logic [`DCFF_IR_STAGES-2:0] full_pipe_r;
  logic [`DCFF_OR_STAGES-2:0] ovalid_pipe_r;
  logic [`DCFF_STD_FLAG_STAGES-1:0] empty_pipe_nxt;
  logic [`DCFF_IR_STAGES-1:0] full_pipe_nxt;
  logic [`DCFF_OR_STAGES-1:0] ovalid_pipe_nxt;
  assign empty_pipe_nxt = {empty_pipe_r, raw.empty_n};
  assign full_pipe_nxt = {full_pipe_r, raw.full_n};
  assign ovalid_pipe_nxt = {ovalid_pipe_r, out_valid_r};

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      empty_pipe_r <= '0;
    end
    else
    begin
      empty_pipe_r <= empty_pipe_nxt[`DCFF_STD_FLAG_STAGES-2:0];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      full_pipe_r <= '1;
    end
    else
    begin
      full_pipe_r <= full_pipe_nxt[`DCFF_IR_STAGES-2:0];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ovalid_pipe_r <= '0;
    end
    else
    begin
      ovalid_pipe_r <= ovalid_pipe_nxt[`DCFF_OR_STAGES-2:0];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      empty_flag_n <= 1'b0;
      full_flag_n <= 1'b1;
      output_ready_n <= 1'b1;
      input_ready_n <= 1'b1;
      almost_empty_n <= 1'b0;
      almost_full_n <= 1'b1;
      half_full_n <= 1'b1;
      serial_load_sel <= 1'b0;
    end
    else
    begin
      // unused mode pins sit at their idle level
      empty_flag_n <= is_ft ? 1'b1 : empty_pipe_r[`DCFF_STD_FLAG_STAGES-2];
      full_flag_n <= is_ft ? 1'b1 : full_pipe_r[`DCFF_STD_FLAG_STAGES-2];
      output_ready_n <= is_ft ? ~ovalid_pipe_r[`DCFF_OR_STAGES-2] : 1'b1;
      input_ready_n <= (is_ft && ready_r) ? ~full_pipe_r[`DCFF_IR_STAGES-2] : 1'b1;
      almost_empty_n <= raw.almost_empty_n;
      almost_full_n <= raw.almost_full_n;
      half_full_n <= raw.half_full_n;
      serial_load_sel <= (load_r == DCFF_LOAD_SERIAL);
    end
  end

endmodule // dcff_fifo

/* core/dcff_pkg.sv */
/*
  dcff_pkg: types shared by the dual clock fifo core.
  assumes: nothing beyond a SystemVerilog tool.
*/
package dcff_pkg;

  // -------------------------------------------------------------------
  // timing mode and offset loading method
  // -------------------------------------------------------------------
  typedef enum logic {DCFF_MODE_STD, DCFF_MODE_FT} dcff_mode_t;
  typedef enum logic {DCFF_LOAD_PARALLEL, DCFF_LOAD_SERIAL} dcff_load_t;

  // -------------------------------------------------------------------
  // raw status flags, active low as on the pins
  // -------------------------------------------------------------------
  typedef struct packed {
    logic empty_n;
    logic full_n;
    logic almost_empty_n;
    logic almost_full_n;
    logic half_full_n;
  } dcff_flags_t;

endpackage

/* core/dcff_regs.svh */
/*
  dcff_regs.svh: offset defaults, timing counts and flag pipeline depths.
  assumes: included by the fifo core by bare name.
*/
`ifndef DCFF_REGS_SVH
`define DCFF_REGS_SVH

// ---------------------------------------------------------------------
// offset defaults chosen at master reset
// ---------------------------------------------------------------------
`define DCFF_OFFSET_SERIAL_DEF 32'h0000_03FF
`define DCFF_OFFSET_PARALLEL_DEF 32'h0000_007F

// ---------------------------------------------------------------------
// timing counts, in edges or stages
// ---------------------------------------------------------------------
`define DCFF_FT_EDGES 2'h3
`define DCFF_STD_FLAG_STAGES 2
`define DCFF_OR_STAGES 3
`define DCFF_IR_STAGES 2
`define DCFF_STRAP_WAIT 2'h2

`endif
